//--- design/ssq_sequencer.sv
// Subinstruction sequencer: step selection, timing and control pulses
//
// Functional notes
// - Divide runs stages 0,1,3,7,6,4 then 2
// - Interrupt entry runs stages 0,1,2 under 10.7
// - Double clear add/sub run stages 0,1,2
// - Counter steps use no order code or stage
// - Indirect read puts addressed register on lines
// - Constant read drives thirteen (16'h000d) onto write lines
// - Every write clears destination, then loads it
// - Return register write loads only that register
// - Indirect write clears, loads addressed register
// - Minus-zero test sets branch flag two
// - Accumulator copied to X without write lines
// - Carry pulse loads one into adder carry
// - Next instruction reads buffer, loads order at 12
// - Stage reset pulse restarts from stage zero
// - Twelve one-microsecond periods per memory cycle
// - Stage output equals the step's digit
// - Stage advance complements the next higher bit
`timescale 1ns/1ns
`default_nettype none

module ssq_sequencer (
	// Clock, reset and enable
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rstn,
	input  wire logic                       i_ce,
	// Requests from surrounding logic
	input  wire logic                       i_go_start_req,
	input  wire logic                       i_interrupt_req,
	input  wire logic                       i_count_req,
	input  wire ssq_pkg::ssq_count_t        i_count_kind,
	input  wire logic                       i_extend,
	// Register data sources
	input  wire logic [ssq_pkg::WL_W-1:0]   i_buffer_data,
	input  wire logic [ssq_pkg::WL_W-1:0]   i_cp_rdata,
	input  wire logic [ssq_pkg::WL_W-1:0]   i_acc_data,
	input  wire logic [ssq_pkg::WL_W-1:0]   i_test_data,
	input  wire logic [ssq_pkg::WL_W-1:0]   i_s_addr,
	// Control pulses and write lines
	output ssq_pkg::ssq_pulse_t             o_pulse,
	output logic [ssq_pkg::WL_W-1:0]        o_wl,
	output ssq_pkg::ssq_wr_t                o_wr,
	output logic [ssq_pkg::WL_W-1:0]        o_cp_addr,
	// Direct exchange
	output logic [ssq_pkg::WL_W-1:0]        o_x_data,
	output logic                            o_x_load,
	output logic                            o_carry_set,
	output logic                            o_branch_flag_two,
	// Sequencer state
	output logic [ssq_pkg::SQ_W-1:0]        o_instruction_register,
	output logic [2:0]                      o_stage,
	output ssq_pkg::ssq_family_t            o_family,
	output ssq_pkg::ssq_count_t             o_count_kind,
	output logic [3:0]                      o_tp
);
	import ssq_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [CYC_W-1:0] cyc;
	logic [3:0]       tp;
	logic [SQ_W-1:0]  instruction_register;
	logic [2:0]       stage;
	ssq_family_t      family;
	ssq_count_t       count_kind;
	ssq_pulse_t       cur;
	logic             period_end;
	logic             mct_end;
	logic             last_step;
	logic             counter_step;

	// Johnson-style advance: shift up and complement the top bit in
	function automatic logic [2:0] advance(input logic [2:0] s);
		advance = {s[1:0], ~s[2]};
	endfunction

	// Family of the sequence that an order code selects
	function automatic ssq_family_t fam_of(input logic [SQ_W-1:0] sq);
		logic       ext;
		logic [2:0] op;
		logic [2:0] qc;
		ext = sq[SQ_W-1];
		op  = sq[5:3];
		qc  = sq[2:0];
		fam_of = FAM_GENERAL;
		if (!ext && op == OP_TRANSFER) begin
			fam_of = FAM_TRANSFER;
		end else if (!ext && op == OP_BRANCH && qc[2:1] != 2'h0) begin
			fam_of = FAM_TRANSFER;
		end else if (ext && op == OP_TRANSFER && qc == QC_ENTRY) begin
			fam_of = FAM_INTERRUPT;
		end else if (ext && op == OP_DIVIDE && qc[2:1] == 2'h0) begin
			fam_of = FAM_DIVIDE;
		end else if (ext && (op == OP_DC_ADD || op == OP_DC_SUB)) begin
			fam_of = FAM_DOUBLE;
		end else if (ext && op == OP_MULTIPLY) begin
			fam_of = FAM_MULTIPLY;
		end
	endfunction

	// ------------------------------------------------------------------
	// Sequence end detection
	// ------------------------------------------------------------------
	always_comb begin
		counter_step = (family == FAM_COUNT);
		case (family)
			FAM_TRANSFER:  last_step = (stage == STG_0);
			FAM_MULTIPLY:  last_step = (stage == STG_3);
			FAM_GO_START:  last_step = 1'b0;
			FAM_COUNT:     last_step = 1'b0;
			default:       last_step = (stage == STG_2);
		endcase
	end

	// ------------------------------------------------------------------
	// Pulse table: which pulse fires in which timing period
	// ------------------------------------------------------------------
	always_comb begin
		cur = '0;
		if (tp == TP_SEL && !counter_step && family != FAM_GO_START) begin
			cur.indirect_register_read_pulse = 1'b1;
		end
		case (family)
			FAM_TRANSFER: begin
				cur.return_reg_write_pulse = (tp == TP_XFER);
			end
			FAM_DIVIDE: begin
				cur.acc_to_x_direct_pulse = (tp == TP_XFER && stage == STG_0);
				cur.minus_zero_test_pulse = (tp == TP_TEST && stage != STG_2);
			end
			FAM_MULTIPLY, FAM_DOUBLE: begin
				cur.acc_to_x_direct_pulse = (tp == TP_XFER && stage == STG_0);
				cur.central_reg_or_carry_pulse = (tp == TP_CARRY &&
					stage == STG_1);
			end
			FAM_INTERRUPT: begin
				cur.const_fifteen_read_pulse = (tp == TP_XFER &&
					stage == STG_1);
				cur.indirect_register_write_pulse = (tp == TP_TEST &&
					stage == STG_1);
			end
			FAM_COUNT: begin
				cur.indirect_register_read_pulse = (tp == TP_XFER);
				cur.indirect_register_write_pulse = (tp == TP_CARRY);
			end
			default: begin
			end
		endcase
		// Shared store step closes every sequence that ends at stage 2
		if (stage == STG_2 && tp == TP_STORE && family != FAM_COUNT &&
			family != FAM_TRANSFER && family != FAM_GO_START) begin
			cur.indirect_register_write_pulse = 1'b1;
		end
		if (tp == TP_LAST) begin
			// Reload SQ only when the instruction is finished
			cur.next_instruction_pulse    = last_step;
			cur.buffer_read_pulse         = last_step;
			cur.instr_reg_write_pulse     = last_step;
			cur.stage_counter_reset_pulse = last_step;
			cur.stage_advance_pulse = (family == FAM_DIVIDE &&
				stage != STG_4 && stage != STG_2) ||
				(family == FAM_MULTIPLY && stage != STG_3) ||
				((family == FAM_INTERRUPT || family == FAM_DOUBLE) &&
				stage == STG_0);
		end
	end

	assign period_end = (cyc == CYC_LAST);
	assign mct_end    = period_end && (tp == TP_LAST);

	// ------------------------------------------------------------------
	// Timing: cycles within a period, twelve periods per memory cycle
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cyc <= '0;
			tp  <= TP_FIRST;
		end else if (i_ce) begin
			if (period_end) begin
				cyc <= '0;
				tp  <= (tp == TP_LAST) ? TP_FIRST : tp + 4'h1;
			end else begin
				cyc <= cyc + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// Step selection at the end of each memory cycle
	// ------------------------------------------------------------------
	// Go-to-start beats everything; counter steps and the interrupt
	// only slip in at an instruction boundary or after a counter step.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			family     <= FAM_GO_START;
			stage      <= STG_1;
			count_kind <= plus_increment_step;
		end else if (i_ce && mct_end) begin
			if (i_go_start_req) begin
				family <= FAM_GO_START;
				stage  <= STG_1;
			end else if (family == FAM_GO_START) begin
				family <= FAM_TRANSFER;
				stage  <= STG_0;
			end else if ((last_step || counter_step) && i_count_req) begin
				// A finished order still gets its stage reset first
				family     <= FAM_COUNT;
				count_kind <= i_count_kind;
				stage      <= STG_0;
			end else if ((last_step || counter_step) && i_interrupt_req) begin
				family <= FAM_INTERRUPT;
				stage  <= STG_0;
			end else if (last_step || counter_step) begin
				family <= fam_of(next_sq_view());
				stage  <= counter_step ? stage : STG_0;
			end else if (cur.stage_advance_pulse) begin
				stage <= advance(stage);
			end else begin
				stage <= STG_2;
			end
		end
	end

	// Order code the next step will run under
	function automatic logic [SQ_W-1:0] next_sq_view();
		next_sq_view = instruction_register;
	endfunction

	// ------------------------------------------------------------------
	// Instruction register: cleared, then loaded from the write lines
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			instruction_register <= SQ_RESET;
		end else if (i_ce) begin
			if (mct_end && i_go_start_req) begin
				instruction_register <= SQ_GO_START;
			end else if (mct_end && (last_step || counter_step) &&
				!i_count_req && i_interrupt_req) begin
				instruction_register <= SQ_INTERRUPT;
			end else if (cur.instr_reg_write_pulse && cyc == CYC_CLEAR) begin
				instruction_register <= SQ_RESET;
			end else if (cur.instr_reg_write_pulse && cyc == CYC_LOAD) begin
				instruction_register <= {i_extend,
					o_wl[WL_SQ_LSB +: SQ_W-1]};
			end
		end
	end

	// ------------------------------------------------------------------
	// Write lines; buffer read wins over the other sources
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wl      <= WL_RESET;
			o_cp_addr <= WL_RESET;
		end else if (i_ce) begin
			o_cp_addr <= i_s_addr;
			if (cur.buffer_read_pulse) begin
				o_wl <= i_buffer_data;
			end else if (cur.const_fifteen_read_pulse) begin
				o_wl <= CONST_FIFTEEN;
			end else if (cur.indirect_register_read_pulse) begin
				o_wl <= i_cp_rdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Write strobes: clear in the first cycle of a period, load next
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wr <= '0;
		end else if (i_ce) begin
			o_wr.ret_clear <= cur.return_reg_write_pulse &&
				cyc == CYC_CLEAR;
			o_wr.ret_load  <= cur.return_reg_write_pulse &&
				cyc == CYC_LOAD;
			o_wr.cp_clear  <= cur.indirect_register_write_pulse &&
				cyc == CYC_CLEAR;
			o_wr.cp_load   <= cur.indirect_register_write_pulse &&
				cyc == CYC_LOAD;
		end
	end

	// ------------------------------------------------------------------
	// Direct exchange, carry insert and branch test
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_x_data          <= WL_RESET;
			o_x_load          <= 1'b0;
			o_carry_set       <= 1'b0;
			o_branch_flag_two <= 1'b0;
		end else if (i_ce) begin
			// X bypasses the write lines so o_wl is left untouched
			o_x_load    <= cur.acc_to_x_direct_pulse &&
				cyc == CYC_LOAD;
			o_carry_set <= cur.central_reg_or_carry_pulse &&
				cyc == CYC_LOAD;
			if (cur.acc_to_x_direct_pulse && cyc == CYC_LOAD) begin
				o_x_data <= i_acc_data;
			end
			if (cur.minus_zero_test_pulse && cyc == CYC_LOAD) begin
				o_branch_flag_two <= (i_test_data == MINUS_ZERO);
			end
		end
	end

	// ------------------------------------------------------------------
	// Visible state
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pulse                <= '0;
			o_instruction_register <= SQ_RESET;
			o_stage                <= STG_1;
			o_family               <= FAM_GO_START;
			o_count_kind           <= plus_increment_step;
			o_tp                   <= TP_FIRST;
		end else if (i_ce) begin
			o_pulse                <= cur;
			o_instruction_register <= instruction_register;
			o_stage                <= stage;
			o_family               <= family;
			o_count_kind           <= count_kind;
			o_tp                   <= tp;
		end
	end

endmodule

`default_nettype wire

//--- design/ssq_pkg.sv
// Shared constants and carrier types for the subinstruction sequencer
package ssq_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ      = 250;
	localparam int TP_PERIOD_NS = 1000;
	localparam int TP_CYCLES    = TP_PERIOD_NS * CLK_MHZ / 1000;
	localparam int TP_PER_MEM   = 12;
	localparam int CYC_W        = 8;
	localparam logic [CYC_W-1:0] CYC_LAST  = 8'(TP_CYCLES - 1);
	localparam logic [CYC_W-1:0] CYC_CLEAR = 8'h00;
	localparam logic [CYC_W-1:0] CYC_LOAD  = 8'h01;
	localparam logic [3:0] TP_FIRST  = 4'h1;
	localparam logic [3:0] TP_LAST   = 4'(TP_PER_MEM);
	localparam logic [3:0] TP_SEL    = 4'h1;
	localparam logic [3:0] TP_XFER   = 4'h2;
	localparam logic [3:0] TP_TEST   = 4'h3;
	localparam logic [3:0] TP_CARRY  = 4'h4;
	localparam logic [3:0] TP_STORE  = 4'h5;

	// ------------------------------------------------------------------
	// Data and instruction register layout
	// ------------------------------------------------------------------
	localparam int WL_W       = 16;
	localparam int SQ_W       = 7;
	localparam int WL_SQ_LSB  = 10;
	localparam logic [WL_W-1:0] CONST_FIFTEEN = 16'h000d;
	localparam logic [WL_W-1:0] MINUS_ZERO    = 16'hffff;
	localparam logic [WL_W-1:0] WL_RESET      = 16'h0000;
	localparam logic [SQ_W-1:0] SQ_RESET      = 7'h00;
	localparam logic [SQ_W-1:0] SQ_GO_START   = 7'h00;
	localparam logic [SQ_W-1:0] SQ_INTERRUPT  = 7'h47;
	localparam logic [2:0] OP_DIVIDE   = 3'h1;
	localparam logic [2:0] OP_DC_ADD   = 3'h3;
	localparam logic [2:0] OP_DC_SUB   = 3'h4;
	localparam logic [2:0] OP_MULTIPLY = 3'h7;
	localparam logic [2:0] OP_TRANSFER = 3'h0;
	localparam logic [2:0] OP_BRANCH   = 3'h1;
	localparam logic [2:0] QC_ENTRY    = 3'h7;

	// ------------------------------------------------------------------
	// Stage counter values
	// ------------------------------------------------------------------
	localparam logic [2:0] STG_0 = 3'h0;
	localparam logic [2:0] STG_1 = 3'h1;
	localparam logic [2:0] STG_2 = 3'h2;
	localparam logic [2:0] STG_3 = 3'h3;
	localparam logic [2:0] STG_4 = 3'h4;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		FAM_TRANSFER, FAM_GENERAL, FAM_DIVIDE, FAM_MULTIPLY,
		FAM_INTERRUPT, FAM_DOUBLE, FAM_GO_START, FAM_COUNT
	} ssq_family_t;

	typedef enum logic [2:0] {
		plus_increment_step, minus_increment_step, diminish_step,
		minus_angle_count_step, shift_count_step, shift_add_count_step
	} ssq_count_t;

	typedef struct packed {
		logic indirect_register_read_pulse;
		logic const_fifteen_read_pulse;
		logic buffer_read_pulse;
		logic return_reg_write_pulse;
		logic indirect_register_write_pulse;
		logic instr_reg_write_pulse;
		logic minus_zero_test_pulse;
		logic acc_to_x_direct_pulse;
		logic central_reg_or_carry_pulse;
		logic next_instruction_pulse;
		logic stage_counter_reset_pulse;
		logic stage_advance_pulse;
	} ssq_pulse_t;

	typedef struct packed {
		logic ret_clear;
		logic ret_load;
		logic cp_clear;
		logic cp_load;
	} ssq_wr_t;

endpackage

//--- design/unused_placeholder_none.sv
// Intentionally empty design unit list: sequencer has no further files
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- test/ssq_sequencer_chk.sv
// Concurrent checks on the subinstruction sequencer ports
`timescale 1ns/1ns
`default_nettype none

module ssq_sequencer_chk (
	// Clock and reset
	input wire logic                 i_clk_sys,
	input wire logic                 i_rstn,
	input wire logic                 i_ce,
	// Data sources
	input wire logic                 i_extend,
	input wire logic [15:0]          i_buffer_data,
	input wire logic [15:0]          i_cp_rdata,
	input wire logic [15:0]          i_acc_data,
	input wire logic [15:0]          i_test_data,
	input wire logic [15:0]          i_s_addr,
	// Pulses and results
	input wire ssq_pkg::ssq_pulse_t  o_pulse,
	input wire logic [15:0]          o_wl,
	input wire ssq_pkg::ssq_wr_t     o_wr,
	input wire logic [15:0]          o_cp_addr,
	input wire logic [15:0]          o_x_data,
	input wire logic                 o_x_load,
	input wire logic                 o_carry_set,
	input wire logic                 o_branch_flag_two,
	input wire logic [6:0]           o_instruction_register,
	input wire logic [2:0]           o_stage,
	input wire ssq_pkg::ssq_family_t o_family,
	input wire logic [3:0]           o_tp
);
	import ssq_pkg::*;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	// ------------------------------------------------------------
	// Timing period length
	// ------------------------------------------------------------
	logic [3:0] tp_q;
	logic [8:0] tp_cnt;
	logic       tp_primed;

	// Counts enabled edges per period; first period after reset skipped
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			tp_q <= TP_FIRST;
			tp_cnt <= 9'h000;
			tp_primed <= 1'b0;
		end else begin
			tp_q <= o_tp;
			if (o_tp != tp_q) begin
				tp_cnt <= 9'h000;
				tp_primed <= 1'b1;
			end else if (i_ce) begin
				tp_cnt <= tp_cnt + 9'h001;
			end
		end
	end

	// ------------------------------------------------------------
	// Step sequences
	// ------------------------------------------------------------
	sequence s_ret_write;
		o_wr.ret_clear ##1 (o_wr.ret_load && !o_wr.cp_load);
	endsequence
	sequence s_cp_write;
		o_wr.cp_clear ##1 (o_wr.cp_load && o_cp_addr == i_s_addr);
	endsequence
	sequence s_fetch;
		(o_pulse.buffer_read_pulse && o_pulse.instr_reg_write_pulse &&
			o_wl == i_buffer_data) ##[1:3]
			(o_instruction_register == {i_extend, o_wl[15:10]});
	endsequence

	a_tp_period_len: assert property ((o_tp != tp_q) && tp_primed |->
		tp_cnt == 9'd249) else $error("timing period length wrong");
	a_go_start_stage: assert property (o_family == FAM_GO_START |->
		o_stage == STG_1) else $error("go-start step not at stage 1");
	a_const_read: assert property ($rose(o_pulse.const_fifteen_read_pulse)
		|-> o_wl == CONST_FIFTEEN) else $error("constant read wrong");
	a_indirect_read: assert property (
		$rose(o_pulse.indirect_register_read_pulse) |-> o_wl == i_cp_rdata)
		else $error("indirect read wrong");
	a_ret_write_only: assert property ($rose(o_wr.ret_clear) |->
		s_ret_write) else $error("return register write wrong");
	a_cp_write_seq: assert property ($rose(o_wr.cp_clear) |->
		s_cp_write) else $error("indirect write wrong");
	a_minus_zero_test: assert property (
		$rose(o_pulse.minus_zero_test_pulse) |=>
		o_branch_flag_two == (i_test_data == MINUS_ZERO))
		else $error("branch flag two wrong");
	a_acc_to_x: assert property ($rose(o_pulse.acc_to_x_direct_pulse)
		|=> o_x_load && o_x_data == i_acc_data) else $error("x copy wrong");
	a_carry_insert: assert property (
		$rose(o_pulse.central_reg_or_carry_pulse) |=> o_carry_set)
		else $error("carry insert missing");
	a_next_fetch: assert property (
		$rose(o_pulse.next_instruction_pulse) |-> s_fetch)
		else $error("next instruction fetch wrong");
	a_gray_step: assert property (o_family == FAM_DIVIDE &&
		$past(o_family) == FAM_DIVIDE && o_stage != $past(o_stage) &&
		o_stage != STG_2 |-> $countones(o_stage ^ $past(o_stage)) == 1)
		else $error("stage advance not one bit");
endmodule

bind ssq_sequencer ssq_sequencer_chk u_chk (.i_clk_sys, .i_rstn, .i_ce,
	.i_extend, .i_buffer_data, .i_cp_rdata, .i_acc_data, .i_test_data,
	.i_s_addr, .o_pulse, .o_wl, .o_wr, .o_cp_addr, .o_x_data, .o_x_load,
	.o_carry_set, .o_branch_flag_two, .o_instruction_register, .o_stage,
	.o_family, .o_tp);

`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the subinstruction sequencer
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import ssq_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic         i_clk_sys, i_rstn, i_ce, i_go_start_req;
	logic         i_interrupt_req, i_count_req, i_extend;
	ssq_count_t   i_count_kind, o_count_kind;
	logic [15:0]  i_buffer_data, i_cp_rdata, i_acc_data;
	logic [15:0]  i_test_data, i_s_addr, o_wl, o_cp_addr, o_x_data;
	ssq_pulse_t   o_pulse;
	ssq_wr_t      o_wr;
	logic         o_x_load, o_carry_set, o_branch_flag_two;
	logic [6:0]   o_instruction_register;
	logic [2:0]   o_stage;
	ssq_family_t  o_family;
	logic [3:0]   o_tp;
	int           err_total, num_checks;

	ssq_sequencer u_dut (.i_clk_sys, .i_rstn, .i_ce, .i_go_start_req,
		.i_interrupt_req, .i_count_req, .i_count_kind, .i_extend,
		.i_buffer_data, .i_cp_rdata, .i_acc_data, .i_test_data, .i_s_addr,
		.o_pulse, .o_wl, .o_wr, .o_cp_addr, .o_x_data, .o_x_load,
		.o_carry_set, .o_branch_flag_two, .o_instruction_register,
		.o_stage, .o_family, .o_count_kind, .o_tp);

	// Free-running 4 ns clock
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Inputs move 1 ns after the edge so no race with sampling
	task automatic tick(int n = 1);
		repeat (n) begin
			@(posedge i_clk_sys);
			#1;
		end
	endtask

	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_step(logic [2:0] stg, ssq_family_t fam,
		logic [6:0] sq);
		chk("stage", {13'h0, stg}, {13'h0, o_stage});
		chk("family", {12'h0, fam}, {12'h0, o_family});
		chk("order", {9'h0, sq}, {9'h0, o_instruction_register});
	endtask

	// Bounded wait for the next memory cycle, then settle into TP1
	task automatic memory_cycle();
		int i;
		for (i = 0; i < 3100 && o_tp !== TP_LAST; i++)
			tick();
		for (i = 0; i < 300 && o_tp !== TP_FIRST; i++)
			tick();
		tick(10);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Fetch one order from the buffer and follow its stage walk
	task automatic run_instr(string name, logic [6:0] sq,
		ssq_family_t fam, logic [23:0] seq, int n, bit entry);
		int k;
		i_extend = sq[6];
		i_buffer_data = {sq[5:0], 10'h000};
		i_interrupt_req = entry;
		for (k = 0; k < n; k++) begin
			memory_cycle();
			i_interrupt_req = 1'b0;
			i_test_data = k[0] ? 16'h0000 : MINUS_ZERO;
			chk_step(seq[23-3*k -: 3], fam, entry ? SQ_INTERRUPT : sq);
		end
		$display("done %s", name);
	endtask

	// Every counter step kind, back to back, then the held order resumes
	task automatic count_steps();
		int k;
		i_buffer_data = 16'h0000;
		i_extend = 1'b0;
		i_count_req = 1'b1;
		for (k = 0; k < 6; k++) begin
			i_count_kind = ssq_count_t'(k);
			memory_cycle();
			chk_step(STG_0, FAM_COUNT, SQ_RESET);
			chk("kind", 16'(k), {13'h0, o_count_kind});
			if (k == 5)
				i_count_req = 1'b0;
		end
		memory_cycle();
		chk_step(STG_0, FAM_TRANSFER, SQ_RESET);
		$display("done count");
	endtask

	// Clock enable low must hold the timing period still
	task automatic freeze();
		memory_cycle();
		i_ce = 1'b0;
		tick(300);
		chk("frozen tp", {12'h0, TP_FIRST}, {12'h0, o_tp});
		i_ce = 1'b1;
		$display("done freeze");
	endtask

	// Go-start aborts a divide in mid-sequence
	task automatic go_start();
		i_extend = 1'b1;
		i_buffer_data = 16'h2000;
		memory_cycle();
		i_go_start_req = 1'b1;
		i_buffer_data = 16'h0000;
		i_extend = 1'b0;
		memory_cycle();
		i_go_start_req = 1'b0;
		chk("stage", {13'h0, STG_1}, {13'h0, o_stage});
		memory_cycle();
		chk_step(STG_0, FAM_TRANSFER, SQ_GO_START);
		$display("done go start");
	endtask

	// Hang guard, reckoned from 31 memory cycles plus margin
	initial begin
		#420000;
		err_total++;
		results();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{i_rstn, i_ce, i_go_start_req, i_interrupt_req} = 4'h0;
		{i_count_req, i_extend} = 2'h0;
		i_count_kind = plus_increment_step;
		i_buffer_data = 16'h0000;
		i_cp_rdata = 16'h1234;
		i_acc_data = 16'h5a5a;
		i_test_data = MINUS_ZERO;
		i_s_addr = 16'h0021;
		tick(2);
		chk("reset stage", {13'h0, STG_1}, {13'h0, o_stage});
		chk("reset tp", {12'h0, TP_FIRST}, {12'h0, o_tp});
		i_rstn = 1'b1;
		i_ce = 1'b1;
		tick(10);
		chk_step(STG_1, FAM_GO_START, SQ_RESET);
		memory_cycle();
		chk_step(STG_0, FAM_TRANSFER, SQ_GO_START);
		run_instr("divide", 7'h48, FAM_DIVIDE, 24'h05fd10, 7, 0);
		run_instr("multiply", 7'h78, FAM_MULTIPLY, 24'h058000, 3, 0);
		run_instr("dc add", 7'h58, FAM_DOUBLE, 24'h050000, 3, 0);
		run_instr("dc sub", 7'h60, FAM_DOUBLE, 24'h050000, 3, 0);
		run_instr("interrupt", 7'h00, FAM_INTERRUPT, 24'h050000, 3, 1);
		count_steps();
		freeze();
		go_start();
		results();
	end
endmodule

`default_nettype wire
